// >>> design/svd_pkg.sv
// package: register map, fields and timing for the supply threshold detector
`default_nettype none
package svd_pkg;
    // register byte offsets on the apb bus
    localparam logic [7:0] SVD_ADDR_CONTROL  = 8'h00;
    localparam logic [7:0] SVD_ADDR_CORE     = 8'h04;
    localparam logic [7:0] SVD_ADDR_FLAGS    = 8'h08;
    localparam logic [7:0] SVD_ADDR_ENABLES  = 8'h0C;
    localparam logic [7:0] SVD_ADDR_PRIORITY = 8'h10;
    localparam logic [7:0] SVD_ADDR_MASK     = 8'h14;
    // control register fields
    localparam int SVD_BIT_DIRECTION  = 7;
    localparam int SVD_BIT_BANDGAP    = 6;
    localparam int SVD_BIT_REF_STABLE = 5;
    localparam int SVD_BIT_ENABLE     = 4;
    localparam int SVD_TRIP_MSB       = 3;
    localparam logic [3:0] SVD_TRIP_EXTERNAL = 4'hF;
    // shared bit position of the detect flag, enable and priority
    localparam int SVD_BIT_DETECT = 2;
    // global enable in the core interrupt control register
    localparam int SVD_BIT_GLOBAL = 7;
    // reset values
    localparam logic [7:0] SVD_RESET_CONTROL = 8'h00;
    localparam logic [7:0] SVD_RESET_CORE    = 8'h00;
    localparam logic [7:0] SVD_RESET_FLAGS   = 8'h00;
    localparam logic [7:0] SVD_RESET_ENABLES = 8'h00;
    localparam logic [7:0] SVD_RESET_PRIO    = 8'h00;
    localparam logic [7:0] SVD_RESET_MASK    = 8'h00;
    // writable bits of the control register (bits 6 and 5 are status)
    localparam logic [7:0] SVD_CONTROL_WMASK = 8'h9F;
    // detect flag bit alone, used by flags, enables, priority and mask
    localparam logic [7:0] SVD_DETECT_MASK   = 8'h04;
    // reference start-up interval, counted in ce-qualified pclk cycles at 100 MHz
    localparam int SVD_CLK_MHZ          = 100;
    localparam int SVD_STARTUP_US       = 25;
    localparam int SVD_STARTUP_CYCLES   = SVD_STARTUP_US * SVD_CLK_MHZ;
    localparam int SVD_BANDGAP_US       = 10;
    localparam int SVD_BANDGAP_CYCLES   = SVD_BANDGAP_US * SVD_CLK_MHZ;
    localparam int SVD_TIMER_W          = 12;
    typedef enum logic [1:0] {
        SVD_OFF,
        SVD_SETTLING,
        SVD_ARMED
    } svd_state_t;
endpackage
`default_nettype wire

// >>> design/svd_startup_timer.sv
// start-up timer for the shared reference, restarted on each enable
`default_nettype none
module svd_startup_timer
    import svd_pkg::*;
#(
    parameter logic [SVD_TIMER_W-1:0] CYCLES = SVD_TIMER_W'(SVD_STARTUP_CYCLES)
) (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic ce,
    input  wire logic run,
    output logic      done
);
    logic [SVD_TIMER_W-1:0] count;
    wire                    at_end = (count >= CYCLES - SVD_TIMER_W'(1));
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count <= '0;
            done  <= 1'b0;
        end else if (ce) begin
            if (!run) begin
                count <= '0;
                done  <= 1'b0;
            end else if (!done) begin
                count <= count + SVD_TIMER_W'(1);
                done  <= at_end;
            end
        end
    end
endmodule
`default_nettype wire

// >>> design/svd_crossing_detect.sv
// comparator qualifier: picks the source and the direction of a crossing
`default_nettype none
module svd_crossing_detect
    import svd_pkg::*;
(
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       ce,
    input  wire logic       armed,
    input  wire logic [3:0] trip_level,
    input  wire logic       detect_direction,
    input  wire logic       internal_above,
    input  wire logic       external_above,
    output logic            event_pulse
);
    logic prev_hit;
    // source select from the trip level
    wire use_ext = (trip_level == SVD_TRIP_EXTERNAL);
    wire above   = use_ext ? external_above : internal_above;
    // direction: 1 high event, 0 low event
    wire hit     = detect_direction ? above : !above;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prev_hit    <= 1'b0;
            event_pulse <= 1'b0;
        end else if (ce) begin
            prev_hit    <= hit && armed;
            event_pulse <= hit && armed && !prev_hit;
        end
    end
endmodule
`default_nettype wire

// >>> design/svd_top.sv
// supply threshold detector control, interrupt routing and apb registers
//
// Function
// - four-bit trip level in control bits 3..0 selects sixteen thresholds
// - trip level all ones takes comparator input from external threshold pin
// - comparator reaching the trip point sets the detect flag
// - direction bit one detects high-voltage, zero detects low-voltage events
// - comparator and divider powered only while control bit 4 is set
// - no detect flag until reference stable status is set
// - interrupt needs source enable bit 2 and global enable bit 7 (irq_high/irq_low only; irq output follows flag and mask alone)
// - reference treated unstable after re-enable until start-up elapses
// - start-up timed independent of clock setting; flag blocked meanwhile (timer here counts ce-qualified pclk cycles)
// - detection continues in sleep; crossing sets flag and wakes device
// - after wake, vector only when interrupts are globally enabled
// - any reset returns registers to reset values, detector disabled
// - direction clear watches falls below, set watches rises above
// - reference stable is read-only control bit 5
//
// Register access over APB and the address map were decided locally.
`default_nettype none
module svd_top
    import svd_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        ce,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        internal_above,
    input  wire logic        external_above,
    input  wire logic        sleeping,
    output logic             detector_power,
    output logic             use_external_input,
    output logic [3:0]       trip_select,
    output logic             irq_high,
    output logic             irq_low,
    output logic             wake,
    output logic             vector_on_wake,
    output logic             irq
);
    logic [7:0] control;
    logic [7:0] core;
    logic [7:0] flags;
    logic [7:0] enables;
    logic [7:0] priority_r;
    logic [7:0] mask;
    svd_state_t state;
    svd_state_t next_state;
    logic       ref_stable;
    logic       bandgap_stable;
    logic       event_pulse;

    // address match against one register offset
    function automatic logic reg_hit(input logic [7:0] addr, input logic [7:0] offset);
        return (addr == offset);
    endfunction

    // implemented bits of the enable, priority and mask registers
    function automatic logic [7:0] detect_only(input logic [7:0] value);
        return value & SVD_DETECT_MASK;
    endfunction

    // apb decode
    wire access   = psel && penable && ce;
    wire wr       = access && pwrite && pstrb[0];
    wire hit_ctl  = reg_hit(paddr, SVD_ADDR_CONTROL);
    wire hit_core = reg_hit(paddr, SVD_ADDR_CORE);
    wire hit_flg  = reg_hit(paddr, SVD_ADDR_FLAGS);
    wire hit_en   = reg_hit(paddr, SVD_ADDR_ENABLES);
    wire hit_pri  = reg_hit(paddr, SVD_ADDR_PRIORITY);
    wire hit_msk  = reg_hit(paddr, SVD_ADDR_MASK);
    wire mapped   = hit_ctl || hit_core || hit_flg || hit_en || hit_pri || hit_msk;
    wire [7:0] wbyte = pwdata[7:0];

    wire enabled  = control[SVD_BIT_ENABLE];

    // status bits merged over the writable ones
    wire [7:0] control_view = (control & SVD_CONTROL_WMASK)
                            | ({7'h00, bandgap_stable} << SVD_BIT_BANDGAP)
                            | ({7'h00, ref_stable} << SVD_BIT_REF_STABLE);
    wire [7:0] read_byte;
    assign read_byte = hit_ctl  ? control_view :
                       hit_core ? core :
                       hit_flg  ? flags :
                       hit_en   ? enables :
                       hit_pri  ? priority_r :
                       hit_msk  ? mask : 8'h00;

    // restart the start-up timer on every enable
    svd_startup_timer #(
        .CYCLES (SVD_TIMER_W'(SVD_STARTUP_CYCLES))
    ) u_ref_timer (
        .pclk    (pclk),
        .presetn (presetn),
        .ce      (ce),
        .run     (enabled),
        .done    (ref_stable)
    );

    svd_startup_timer #(
        .CYCLES (SVD_TIMER_W'(SVD_BANDGAP_CYCLES))
    ) u_bg_timer (
        .pclk    (pclk),
        .presetn (presetn),
        .ce      (ce),
        .run     (enabled),
        .done    (bandgap_stable)
    );

    wire armed = (state == SVD_ARMED);

    svd_crossing_detect u_cross (
        .pclk             (pclk),
        .presetn          (presetn),
        .ce               (ce),
        .armed            (armed),
        .trip_level       (control[SVD_TRIP_MSB:0]),
        .detect_direction (control[SVD_BIT_DIRECTION]),
        .internal_above   (internal_above),
        .external_above   (external_above),
        .event_pulse      (event_pulse)
    );

    always_comb begin
        next_state = state;
        case (state)
            SVD_OFF: begin
                if (enabled) begin
                    next_state = SVD_SETTLING;
                end
            end
            SVD_SETTLING: begin
                if (!enabled) begin
                    next_state = SVD_OFF;
                end else if (ref_stable) begin
                    next_state = SVD_ARMED;
                end
            end
            SVD_ARMED: begin
                if (!enabled) begin
                    next_state = SVD_OFF;
                end
            end
            default: next_state = SVD_OFF;
        endcase
    end

    // sticky flag, set wins over a one-to-clear write
    wire       flag_clr  = wr && hit_flg && wbyte[SVD_BIT_DETECT];
    wire [7:0] flag_set  = event_pulse ? SVD_DETECT_MASK : 8'h00;
    wire [7:0] next_flags = (flags & ~(flag_clr ? SVD_DETECT_MASK : 8'h00)) | flag_set;

    // source and global enable gate the cpu interrupt
    wire pending   = flags[SVD_BIT_DETECT] && enables[SVD_BIT_DETECT];
    wire cpu_req   = pending && core[SVD_BIT_GLOBAL];
    wire is_high   = priority_r[SVD_BIT_DETECT];
    // wake from sleep on a flagged, enabled source
    wire next_wake = sleeping && pending;
    // vector after wake only with global enable
    wire next_vec  = next_wake && core[SVD_BIT_GLOBAL];
    wire next_irq  = |(flags & mask);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= SVD_OFF;
        end else if (ce) begin
            state <= next_state;
        end
    end

    // next register values, writes keep only implemented bits
    wire       wr_ctl        = wr && hit_ctl;
    wire       wr_core       = wr && hit_core;
    wire       wr_en         = wr && hit_en;
    wire       wr_pri        = wr && hit_pri;
    wire       wr_msk        = wr && hit_msk;
    wire [7:0] next_control  = wr_ctl ? (wbyte & SVD_CONTROL_WMASK) : control;
    wire [7:0] next_core     = wr_core ? wbyte : core;
    wire [7:0] next_enables  = wr_en ? detect_only(wbyte) : enables;
    wire [7:0] next_priority = wr_pri ? detect_only(wbyte) : priority_r;
    wire [7:0] next_mask     = wr_msk ? detect_only(wbyte) : mask;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            control <= SVD_RESET_CONTROL;
        end else if (ce) begin
            control <= next_control;
        end
    end

    // global enable lives in bit 7
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            core <= SVD_RESET_CORE;
        end else if (ce) begin
            core <= next_core;
        end
    end

    // only bit 2 is implemented in these three
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            enables <= SVD_RESET_ENABLES;
        end else if (ce) begin
            enables <= next_enables;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            priority_r <= SVD_RESET_PRIO;
        end else if (ce) begin
            priority_r <= next_priority;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mask <= SVD_RESET_MASK;
        end else if (ce) begin
            mask <= next_mask;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flags <= SVD_RESET_FLAGS;
        end else if (ce) begin
            flags <= next_flags;
        end
    end

    // apb answer: zero wait states, error on unmapped address
    // read data launched in setup stands through the access cycle
    wire        in_setup     = psel && !penable;
    wire        next_pslverr = in_setup && !mapped;
    wire [31:0] next_prdata  = (in_setup && !pwrite) ? {24'h000000, read_byte} : 32'h0000_0000;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else if (ce) begin
            pready  <= in_setup;
            pslverr <= next_pslverr;
            prdata  <= next_prdata;
        end
    end

    // detector outputs follow the control register
    wire [3:0] trip_level   = control[SVD_TRIP_MSB:0];
    wire       next_use_ext = enabled && (trip_level == SVD_TRIP_EXTERNAL);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            detector_power     <= 1'b0;
            use_external_input <= 1'b0;
            trip_select        <= 4'h0;
        end else if (ce) begin
            detector_power     <= enabled;
            use_external_input <= next_use_ext;
            trip_select        <= trip_level;
        end
    end

    wire next_irq_high = cpu_req && is_high;
    wire next_irq_low  = cpu_req && !is_high;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_high <= 1'b0;
            irq_low  <= 1'b0;
            irq      <= 1'b0;
        end else if (ce) begin
            irq_high <= next_irq_high;
            irq_low  <= next_irq_low;
            irq      <= next_irq;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wake           <= 1'b0;
            vector_on_wake <= 1'b0;
        end else if (ce) begin
            wake           <= next_wake;
            vector_on_wake <= next_vec;
        end
    end
endmodule
`default_nettype wire

// >>> test/svd_top_chk.sv
// checker: port-level assertions for the supply threshold detector
`default_nettype none
module svd_top_chk
    import svd_pkg::*;
(
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        ce,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0]  pstrb,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        sleeping,
    input wire logic        detector_power,
    input wire logic        use_external_input,
    input wire logic [3:0]  trip_select,
    input wire logic        irq_high,
    input wire logic        irq_low,
    input wire logic        wake,
    input wire logic        vector_on_wake
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_ready_pulse: assert property (pready |=> !pready) else $error("pready held too long");
    a_ready_access: assert property (pready |-> psel && penable) else $error("pready outside access");
    a_ready_prompt: assert property ((psel && !penable && ce) ##1 ce |-> pready)
        else $error("no zero-wait answer");
    a_err_ready: assert property (pslverr |-> pready) else $error("pslverr without pready");
    a_rdata_upper: assert property (pready |-> prdata[31:8] == 24'h0) else $error("upper data set");
    a_ext_select: assert property (use_external_input |-> detector_power && trip_select == 4'hF)
        else $error("external input chosen wrongly");
    a_power_write: assert property (psel && penable && pready && pwrite && ce
        && paddr == SVD_ADDR_CONTROL && pstrb[0]
        |-> ##2 detector_power == $past(pwdata[SVD_BIT_ENABLE], 2))
        else $error("detector power does not follow enable");
    a_irq_split: assert property (!(irq_high && irq_low)) else $error("both vectors");
    a_vector_wake: assert property (vector_on_wake |-> wake) else $error("vector without wake");
    a_wake_sleep: assert property (wake && $past(ce) |-> $past(sleeping))
        else $error("wake while awake");
    cover property (pslverr);
    cover property (irq_high);
    cover property (vector_on_wake);
endmodule
bind svd_top svd_top_chk u_chk (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .sleeping(sleeping),
    .detector_power(detector_power), .use_external_input(use_external_input),
    .trip_select(trip_select), .irq_high(irq_high), .irq_low(irq_low), .wake(wake),
    .vector_on_wake(vector_on_wake));
`default_nettype wire

// >>> test/testbench.sv
// testbench: register, detector and interrupt scenarios for svd_top
`default_nettype none
module testbench
    import svd_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        pclk = 0, presetn = 0, ce = 1, psel = 0, penable = 0, pwrite = 0;
    logic        internal_above = 1, external_above = 1, sleeping = 0;
    logic [7:0]  paddr = 0;
    logic [31:0] pwdata = 0, prdata;
    logic [3:0]  pstrb = 4'hF, trip_select;
    logic        pready, pslverr, detector_power, use_external_input;
    logic        irq_high, irq_low, wake, vector_on_wake, irq;
    int          bad_count = 0, n_compared = 0;
    wire [4:0]   outs = {irq_high, irq_low, irq, wake, vector_on_wake};

    always #5 pclk = ~pclk;

    svd_top DUT (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .internal_above(internal_above),
        .external_above(external_above), .sleeping(sleeping), .detector_power(detector_power),
        .use_external_input(use_external_input), .trip_select(trip_select),
        .irq_high(irq_high), .irq_low(irq_low), .wake(wake), .vector_on_wake(vector_on_wake),
        .irq(irq));

    task automatic tally_and_finish;
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d,
                       output logic [31:0] r, output logic e);
        int n;
        @(posedge pclk);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            bad_count++;
            tally_and_finish;
        end else begin
            r = prdata;
            e = pslverr;
            psel <= 0;
            penable <= 0;
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] r;
        logic        e;
        apb(1, a, d, r, e);
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        logic [31:0] r;
        logic        e;
        apb(0, a, 8'h00, r, e);
        chk(r, {24'h0, exp});
    endtask

    // lets registered outputs settle before sampling
    task automatic settle;
        repeat (3) @(posedge pclk);
    endtask

    task automatic t_reset_values;
        logic [7:0]  addrs [6] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14};
        logic [31:0] r;
        logic        e;
        foreach (addrs[i]) rd(addrs[i], 8'h00);
        apb(0, 8'h18, 8'h00, r, e);
        chk(32'(e), 32'h1);
    endtask

    task automatic t_control_fields;
        wr(SVD_ADDR_CONTROL, 8'h6F);
        rd(SVD_ADDR_CONTROL, 8'h0F);
        settle;
        chk(32'(trip_select), 32'hF);
        chk(32'({detector_power, use_external_input}), 32'h0);
    endtask

    task automatic t_detect_and_irq;
        wr(SVD_ADDR_CONTROL, 8'h1F);
        settle;
        chk(32'({detector_power, use_external_input}), 32'h3);
        rd(SVD_ADDR_CONTROL, 8'h1F);
        external_above <= 0;
        settle;
        external_above <= 1;
        repeat (2600) @(posedge pclk);
        rd(SVD_ADDR_CONTROL, 8'h7F);
        rd(SVD_ADDR_FLAGS, 8'h00);
        internal_above <= 0;
        settle;
        rd(SVD_ADDR_FLAGS, 8'h00);
        external_above <= 0;
        settle;
        rd(SVD_ADDR_FLAGS, 8'h04);
        external_above <= 1;
        settle;
        rd(SVD_ADDR_FLAGS, 8'h04);
        wr(SVD_ADDR_ENABLES, 8'h04);
        settle;
        chk(32'(outs), 32'h00);
        wr(SVD_ADDR_CORE, 8'h80);
        settle;
        chk(32'(outs), 32'h08);
        wr(SVD_ADDR_PRIORITY, 8'h04);
        settle;
        chk(32'(outs), 32'h10);
        wr(SVD_ADDR_MASK, 8'h04);
        settle;
        chk(32'(outs), 32'h14);
        sleeping <= 1;
        settle;
        chk(32'(outs), 32'h17);
        wr(SVD_ADDR_CORE, 8'h00);
        settle;
        chk(32'(outs), 32'h06);
        wr(SVD_ADDR_FLAGS, 8'h04);
        rd(SVD_ADDR_FLAGS, 8'h00);
        settle;
        chk(32'(outs), 32'h00);
        sleeping <= 0;
    endtask

    task automatic t_direction_high;
        logic [31:0] r;
        logic        e;
        wr(SVD_ADDR_CONTROL, 8'h0F);
        wr(SVD_ADDR_CONTROL, 8'h83);
        wr(SVD_ADDR_CONTROL, 8'h93);
        apb(0, SVD_ADDR_CONTROL, 8'h00, r, e);
        chk(32'(r[5]), 32'h0);
        repeat (2600) @(posedge pclk);
        rd(SVD_ADDR_FLAGS, 8'h00);
        chk(32'({trip_select, use_external_input}), 32'h06);
        internal_above <= 1;
        settle;
        rd(SVD_ADDR_FLAGS, 8'h04);
    endtask

    task automatic t_mid_reset;
        presetn <= 0;
        repeat (2) @(posedge pclk);
        chk(32'({detector_power, irq}), 32'h0);
        @(posedge pclk);
        presetn <= 1;
        rd(SVD_ADDR_CONTROL, 8'h00);
        rd(SVD_ADDR_FLAGS, 8'h00);
    endtask

    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1;
        t_reset_values;
        t_control_fields;
        t_detect_and_irq;
        t_direction_high;
        t_mid_reset;
        tally_and_finish;
    end
endmodule
`default_nettype wire
